// File: core/phase_servo_clock.sv
// Phase/servo clock generator, hardware clocks and serial DAC shifter
// What this block does
// [RULE1] Max-phase rate 117964.8kHz over 2(div+1)
// [RULE2] Max-phase tick also paces PWM cycle
// [RULE3] Phase clock is max-phase over (div+1)
// [RULE4] Servo clock is phase over (div+1)
// [RULE5] Commutate configured motors every phase cycle
// [RULE6] Servo update every servo cycle, active motors
// [RULE7] Software keeps servo interval matching dividers
// [RULE8] Default dividers give 9.03 kHz phase
// [RULE9] Per bank selects four hardware clock rates
// [RULE10] DAC serial clock defaults to 4.9152 MHz
// [RULE11] Software sets sample clock above edge rate
// [RULE12] 24-bit strobe word MSB first per phase
// [RULE13] Two strobe words, reset to 7FFFC0
// [RULE14] Decode 3 and 7 are x4 quadrature
// [RULE15] Mode 1 or 3 gives DAC outputs
// [RULE16] Inversion flips every serial DAC bit
// [RULE17] Commutate only with commutation enable set
// [RULE18] Motor active only while activation is 1
// [RULE19] Software matches phase angle to direction
// [RULE20] Two phase commands per motor through DACs
// [RULE21] DAC words and strobe start per phase
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module phase_servo_clock (
   input wire logic mclk, // 20 MHz clock
   input wire logic rst, // Sync reset, high
   input wire logic [7:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Byte enables
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [7:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   output logic maxPhaseTick, // Max-phase and PWM cycle pulse
   output logic phaseTick, // Phase clock pulse
   output logic servoTick, // Servo clock pulse
   output logic [7:0] commutateStb, // Per motor commutation pulse
   output logic [7:0] servoUpdStb, // Per motor servo update pulse
   output logic [7:0] hwClkTick, // Bank*4+clock: enc,pfm,dac,adc
   output logic [1:0] dacStrobe, // Strobe bit per bank
   output logic [7:0] phaseAAnalogOut, // Serial data, DAC A
   output logic [7:0] phaseBAnalogOut, // Serial data, DAC B
   output logic [7:0] quadX4, // Channel decodes x4
   output logic [7:0] countUpDir, // Decode direction sense
   output logic [7:0] outCPfm // Output C in pulse mode
);
   ////////////////////////////////////////////////////////////////////////////////////
   logic [15:0] mpDiv_r, mpDiv_nxt;
   logic [3:0] phDiv_r, phDiv_nxt, svDiv_r, svDiv_nxt;
   logic [3:0] phCnt_r, phCnt_nxt, svCnt_r, svCnt_nxt;
   logic [11:0] hwSel_r[2], hwSel_nxt[2];
   logic [23:0] stbWord_r[2], stbWord_nxt[2];
   logic [23:0] svInt_r, svInt_nxt;
   logic [8:0] chCfg_r[8], chCfg_nxt[8];
   logic [9:0] motCfg_r[8], motCfg_nxt[8];
   logic [31:0] dacWord_r[8], dacWord_nxt[8];
   logic [35:0] mpAcc_r, mpAcc_nxt, mpSum, mpMod, mpRem;
   logic [18:0] hwAcc_r[8], hwAcc_nxt[8], hwSum;
   logic [15:0] svCount_r, svCount_nxt;
   logic [7:0] hwTick, commNxt, servoNxt, commGate;
   logic mpTick, phTick, svTick;
   logic [4:0] bitCnt_r[2], bitCnt_nxt[2];
   logic [23:0] stbSh_r[2], stbSh_nxt[2];
   logic [23:0] shA_r[8], shA_nxt[8], shB_r[8], shB_nxt[8];
   logic [1:0] shiftEn, stbNxt;
   logic [7:0] serANxt, serBNxt;
   logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
   logic [7:0] awAddr_r, awAddr_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0] wStrb_r, wStrb_nxt;
   logic awRdyNxt, wRdyNxt, bvNxt, arRdyNxt, rvNxt;
   logic [1:0] brNxt, rrNxt;
   logic [31:0] rdNxt, wrVal;
   logic [32:0] wrCur, rdCur;

   // Register read mux: hit flag above the data word
   function automatic logic [32:0] rdMux(input logic [7:0] a);
      logic [2:0] n;
      n = a[4:2];
      case ({a[7:2], 2'b00})
         phase_servo_pkg::OFF_MAXPH: rdMux = {1'b1, 16'h0000, mpDiv_r};
         phase_servo_pkg::OFF_PHDIV: rdMux = {1'b1, 28'h0000000, phDiv_r};
         phase_servo_pkg::OFF_SVDIV: rdMux = {1'b1, 28'h0000000, svDiv_r};
         phase_servo_pkg::OFF_HWLO: rdMux = {1'b1, 20'h00000, hwSel_r[0]};
         phase_servo_pkg::OFF_HWHI: rdMux = {1'b1, 20'h00000, hwSel_r[1]};
         phase_servo_pkg::OFF_STBLO: rdMux = {1'b1, 8'h00, stbWord_r[0]};
         phase_servo_pkg::OFF_STBHI: rdMux = {1'b1, 8'h00, stbWord_r[1]};
         phase_servo_pkg::OFF_SVINT: rdMux = {1'b1, 8'h00, svInt_r};
         phase_servo_pkg::OFF_STAT: rdMux = {1'b1, svCount_r, 8'h00, phCnt_r, svCnt_r};
         default: begin
            if (a[7:5] == phase_servo_pkg::BLK_CHAN) begin
               rdMux = {1'b1, 23'h000000, chCfg_r[n]};
            end else if (a[7:5] == phase_servo_pkg::BLK_MOT) begin
               rdMux = {1'b1, 22'h000000, motCfg_r[n]};
            end else if (a[7:5] == phase_servo_pkg::BLK_DAC) begin
               rdMux = {1'b1, dacWord_r[n]};
            end else begin
               rdMux = 33'h000000000;
            end
         end
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////
   // Timing chain: max-phase, phase, servo and hardware clock rate generators
   always_comb begin
      // [RULE1] fractional max-phase rate
      mpSum = mpAcc_r + phase_servo_pkg::MP_INC;
      mpMod = 36'(({20'h00000, mpDiv_r} + 36'h1) * phase_servo_pkg::NCO_MOD2);
      mpTick = mpSum >= mpMod;
      mpRem = mpSum - mpMod;
      // A divider cut can leave the sum far above the wrap: restart, never burst ticks
      mpAcc_nxt = !mpTick ? mpSum : (mpRem >= mpMod) ? 36'h000000000 : mpRem;
      // [RULE3] phase divide by (div+1)
      phTick = 1'b0;
      phCnt_nxt = phCnt_r;
      if (mpTick) begin
         phTick = phCnt_r >= phDiv_r;
         phCnt_nxt = phTick ? 4'h0 : phCnt_r + 4'h1;
      end
      // [RULE4] servo divide by (div+1)
      svTick = 1'b0;
      svCnt_nxt = svCnt_r;
      if (phTick) begin
         svTick = svCnt_r >= svDiv_r;
         svCnt_nxt = svTick ? 4'h0 : svCnt_r + 4'h1;
      end
      svCount_nxt = svCount_r + {15'h0000, svTick};
      hwSum = 19'h00000;
      // [RULE9] four rates per bank
      for (int i = 0; i < 8; i++) begin
         hwSum = hwAcc_r[i] + (phase_servo_pkg::HW_INC >>
            hwSel_r[i / 4][(i % 4) * phase_servo_pkg::HW_FW +: phase_servo_pkg::HW_FW]);
         hwTick[i] = hwSum >= phase_servo_pkg::HW_MOD;
         hwAcc_nxt[i] = hwTick[i] ? hwSum - phase_servo_pkg::HW_MOD : hwSum;
      end
      for (int m = 0; m < 8; m++) begin
         // [RULE17] enable and activation gate
         commGate[m] = motCfg_r[m][1] && motCfg_r[m][0];
         commNxt[m] = phTick && commGate[m];
         // [RULE18] active motors only
         servoNxt[m] = svTick && motCfg_r[m][0];
      end
   end

   // Timing registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         mpAcc_r <= 36'h000000000;
         phCnt_r <= 4'h0;
         svCnt_r <= 4'h0;
         svCount_r <= 16'h0000;
         for (int i = 0; i < 8; i++) begin
            hwAcc_r[i] <= 19'h00000;
         end
         maxPhaseTick <= 1'b0;
         phaseTick <= 1'b0;
         servoTick <= 1'b0;
         commutateStb <= 8'h00;
         servoUpdStb <= 8'h00;
         hwClkTick <= 8'h00;
      end else begin
         mpAcc_r <= mpAcc_nxt;
         phCnt_r <= phCnt_nxt;
         svCnt_r <= svCnt_nxt;
         svCount_r <= svCount_nxt;
         hwAcc_r <= hwAcc_nxt;
         // [RULE2] pulse doubles as PWM cycle
         maxPhaseTick <= mpTick;
         phaseTick <= phTick;
         servoTick <= svTick;
         // [RULE5] per phase commutation pulses
         commutateStb <= commNxt;
         // [RULE6] per servo update pulses
         servoUpdStb <= servoNxt;
         hwClkTick <= hwTick;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Serial DAC shifter: strobe and data frames start together each phase
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         shiftEn[b] = !phTick && hwTick[b * 4 + phase_servo_pkg::HW_DAC] &&
            bitCnt_r[b] != 5'd0;
         bitCnt_nxt[b] = bitCnt_r[b];
         stbSh_nxt[b] = stbSh_r[b];
         // [RULE21] frame loads on phase tick
         if (phTick) begin
            bitCnt_nxt[b] = phase_servo_pkg::FRAME_BITS;
            stbSh_nxt[b] = stbWord_r[b];
         end else if (shiftEn[b]) begin
            bitCnt_nxt[b] = bitCnt_r[b] - 5'd1;
            stbSh_nxt[b] = {stbSh_r[b][22:0], 1'b0};
         end
         // [RULE12] MSB first, one bit per DAC clock
         stbNxt[b] = shiftEn[b] && stbSh_r[b][23];
      end
      for (int c = 0; c < 8; c++) begin
         shA_nxt[c] = shA_r[c];
         shB_nxt[c] = shB_r[c];
         // [RULE20] two phase words per motor
         if (phTick) begin
            // [RULE16] inversion covers whole frame
            shA_nxt[c] = {dacWord_r[c][15:0], 8'h00} ^ {24{chCfg_r[c][8]}};
            shB_nxt[c] = {dacWord_r[c][31:16], 8'h00} ^ {24{chCfg_r[c][8]}};
         end else if (shiftEn[c / 4]) begin
            shA_nxt[c] = {shA_r[c][22:0], 1'b0};
            shB_nxt[c] = {shB_r[c][22:0], 1'b0};
         end
         // [RULE15] serial lines only in DAC mode
         serANxt[c] = shiftEn[c / 4] && chCfg_r[c][4] && shA_r[c][23];
         serBNxt[c] = shiftEn[c / 4] && chCfg_r[c][4] && shB_r[c][23];
      end
   end

   // Shifter registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int b = 0; b < 2; b++) begin
            bitCnt_r[b] <= 5'd0;
            stbSh_r[b] <= 24'h000000;
         end
         for (int c = 0; c < 8; c++) begin
            shA_r[c] <= 24'h000000;
            shB_r[c] <= 24'h000000;
         end
         dacStrobe <= 2'h0;
         phaseAAnalogOut <= 8'h00;
         phaseBAnalogOut <= 8'h00;
      end else begin
         bitCnt_r <= bitCnt_nxt;
         stbSh_r <= stbSh_nxt;
         shA_r <= shA_nxt;
         shB_r <= shB_nxt;
         dacStrobe <= stbNxt;
         phaseAAnalogOut <= serANxt;
         phaseBAnalogOut <= serBNxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave and register writes
   always_comb begin
      mpDiv_nxt = mpDiv_r;
      phDiv_nxt = phDiv_r;
      svDiv_nxt = svDiv_r;
      hwSel_nxt = hwSel_r;
      stbWord_nxt = stbWord_r;
      svInt_nxt = svInt_r;
      chCfg_nxt = chCfg_r;
      motCfg_nxt = motCfg_r;
      dacWord_nxt = dacWord_r;
      {awHeld_nxt, awAddr_nxt, wHeld_nxt, wData_nxt, wStrb_nxt} =
         {awHeld_r, awAddr_r, wHeld_r, wData_r, wStrb_r};
      bvNxt = bvalid && !bready;
      brNxt = bresp;
      if (awvalid && awready) begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = awaddr;
      end
      if (wvalid && wready) begin
         wHeld_nxt = 1'b1;
         wData_nxt = wdata;
         wStrb_nxt = wstrb;
      end
      // Merge byte lanes into the current value, then store
      wrCur = rdMux(awAddr_r);
      for (int k = 0; k < 4; k++) begin
         wrVal[k * 8 +: 8] = wStrb_r[k] ? wData_r[k * 8 +: 8] : wrCur[k * 8 +: 8];
      end
      if (awHeld_r && wHeld_r && !bvalid) begin
         awHeld_nxt = 1'b0;
         wHeld_nxt = 1'b0;
         bvNxt = 1'b1;
         brNxt = wrCur[32] ? phase_servo_pkg::RESP_OK : phase_servo_pkg::RESP_ERR;
         case ({awAddr_r[7:2], 2'b00})
            phase_servo_pkg::OFF_MAXPH: mpDiv_nxt = wrVal[15:0];
            phase_servo_pkg::OFF_PHDIV: phDiv_nxt = wrVal[3:0];
            phase_servo_pkg::OFF_SVDIV: svDiv_nxt = wrVal[3:0];
            phase_servo_pkg::OFF_HWLO: hwSel_nxt[0] = wrVal[11:0];
            phase_servo_pkg::OFF_HWHI: hwSel_nxt[1] = wrVal[11:0];
            // [RULE13] separate strobe word per bank
            phase_servo_pkg::OFF_STBLO: stbWord_nxt[0] = wrVal[23:0];
            phase_servo_pkg::OFF_STBHI: stbWord_nxt[1] = wrVal[23:0];
            phase_servo_pkg::OFF_SVINT: svInt_nxt = wrVal[23:0];
            default: begin
               if (awAddr_r[7:5] == phase_servo_pkg::BLK_CHAN) begin
                  chCfg_nxt[awAddr_r[4:2]] = wrVal[8:0];
               end else if (awAddr_r[7:5] == phase_servo_pkg::BLK_MOT) begin
                  motCfg_nxt[awAddr_r[4:2]] = wrVal[9:0];
               end else if (awAddr_r[7:5] == phase_servo_pkg::BLK_DAC) begin
                  dacWord_nxt[awAddr_r[4:2]] = wrVal;
               end
            end
         endcase
      end
      awRdyNxt = !awHeld_nxt;
      wRdyNxt = !wHeld_nxt;
      rvNxt = rvalid && !rready;
      rdNxt = rdata;
      rrNxt = rresp;
      rdCur = rdMux(araddr);
      if (arvalid && arready) begin
         rvNxt = 1'b1;
         rdNxt = rdCur[31:0];
         rrNxt = rdCur[32] ? phase_servo_pkg::RESP_OK : phase_servo_pkg::RESP_ERR;
      end
      arRdyNxt = !rvNxt;
   end

   // Bus and configuration registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         // [RULE8] defaults give 9.03 kHz phase
         mpDiv_r <= phase_servo_pkg::MAXPH_RST;
         phDiv_r <= phase_servo_pkg::PHDIV_RST;
         svDiv_r <= phase_servo_pkg::SVDIV_RST;
         // [RULE10] DAC clock default 4.9152 MHz
         hwSel_r <= '{phase_servo_pkg::HWSEL_RST, phase_servo_pkg::HWSEL_RST};
         stbWord_r <= '{phase_servo_pkg::STROBE_RST, phase_servo_pkg::STROBE_RST};
         svInt_r <= phase_servo_pkg::SVINT_RST;
         for (int c = 0; c < 8; c++) begin
            chCfg_r[c] <= phase_servo_pkg::CHCFG_RST;
            motCfg_r[c] <= 10'h000;
            dacWord_r[c] <= 32'h00000000;
         end
         {awHeld_r, wHeld_r, awAddr_r, wData_r, wStrb_r} <= 46'h0;
         {awready, wready, arready, bvalid, rvalid} <= 5'b00000;
         {bresp, rresp, rdata} <= 36'h0;
         {quadX4, countUpDir, outCPfm} <= 24'h0;
      end else begin
         mpDiv_r <= mpDiv_nxt;
         phDiv_r <= phDiv_nxt;
         svDiv_r <= svDiv_nxt;
         hwSel_r <= hwSel_nxt;
         stbWord_r <= stbWord_nxt;
         svInt_r <= svInt_nxt;
         chCfg_r <= chCfg_nxt;
         motCfg_r <= motCfg_nxt;
         dacWord_r <= dacWord_nxt;
         {awHeld_r, wHeld_r, awAddr_r, wData_r, wStrb_r} <=
            {awHeld_nxt, wHeld_nxt, awAddr_nxt, wData_nxt, wStrb_nxt};
         {awready, wready, arready, bvalid, rvalid} <=
            {awRdyNxt, wRdyNxt, arRdyNxt, bvNxt, rvNxt};
         {bresp, rresp, rdata} <= {brNxt, rrNxt, rdNxt};
         for (int c = 0; c < 8; c++) begin
            // [RULE14] 3 and 7 both decode x4
            quadX4[c] <= chCfg_nxt[c][1:0] == 2'b11;
            countUpDir[c] <= chCfg_nxt[c][2];
            outCPfm[c] <= chCfg_nxt[c][5:4] == 2'b11;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // A divider write may leave the accumulator out of range for one cycle
   mp_acc_a: assert property ($stable(mpDiv_r) |-> mpAcc_r < mpMod) // [RULE1]
      else $error("max-phase acc out of range");
   pwm_pace_a: assert property (phaseTick |-> maxPhaseTick) // [RULE2]
      else $error("phase off max-phase");
   ph_count_a: assert property (maxPhaseTick && !phaseTick && $stable(phDiv_r) // [RULE3]
      |-> phCnt_r != 4'h0 && phCnt_r <= phDiv_r) else $error("phase count wrong");
   sv_phase_a: assert property (servoTick |-> phaseTick && svCnt_r == 4'h0) // [RULE4]
      else $error("servo off phase");
   comm_phase_a: assert property (commutateStb != 8'h00 |-> phaseTick) // [RULE5]
      else $error("commutation off phase");
   comm_gate_a: assert property ((commutateStb & ~$past(commGate)) == 8'h00) // [RULE17]
      else $error("commutation ungated");
   servo_act_a: assert property (servoUpdStb != 8'h00 |-> servoTick) // [RULE6]
      else $error("servo update off servo");
   frame_start_a: assert property (phaseTick |-> bitCnt_r[0] == 5'd24 && bitCnt_r[1] == 5'd24) // [RULE21]
      else $error("frame not loaded");
   strobe_idle_a: assert property (bitCnt_r[0] == 5'd0 |=> dacStrobe[0] == 1'b0) // [RULE12]
      else $error("strobe after frame");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   frame_c: cover property (phaseTick ##1 (bitCnt_r[0] == 5'd23));
   servo_c: cover property (servoTick && servoUpdStb != 8'h00);
   write_c: cover property (bvalid && bready && bresp == 2'h0);
endmodule

// File: core/phase_servo_pkg.sv
// Constants for the phase/servo clock and serial DAC block
package phase_servo_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_MAXPH = 8'h00;
   localparam logic [7:0] OFF_PHDIV = 8'h04;
   localparam logic [7:0] OFF_SVDIV = 8'h08;
   localparam logic [7:0] OFF_HWLO = 8'h0C;
   localparam logic [7:0] OFF_HWHI = 8'h10;
   localparam logic [7:0] OFF_STBLO = 8'h14;
   localparam logic [7:0] OFF_STBHI = 8'h18;
   localparam logic [7:0] OFF_SVINT = 8'h1C;
   localparam logic [7:0] OFF_STAT = 8'h20;
   localparam logic [2:0] BLK_CHAN = 3'h2; // 0x40..0x5C
   localparam logic [2:0] BLK_MOT = 3'h3; // 0x60..0x7C
   localparam logic [2:0] BLK_DAC = 3'h4; // 0x80..0x9C
   // Values after reset
   localparam logic [15:0] MAXPH_RST = 16'h197F;
   localparam logic [3:0] PHDIV_RST = 4'h0;
   localparam logic [3:0] SVDIV_RST = 4'h3;
   localparam logic [11:0] HWSEL_RST = 12'h492;
   localparam logic [23:0] STROBE_RST = 24'h7FFFC0;
   localparam logic [23:0] SVINT_RST = 24'h38ABF3;
   localparam logic [8:0] CHCFG_RST = 9'h013;
   // Hardware clock field positions inside a clock select word
   localparam int HW_ENC = 0;
   localparam int HW_PFM = 1;
   localparam int HW_DAC = 2;
   localparam int HW_ADC = 3;
   localparam int HW_FW = 3;
   // Rate generation, in units of 100 Hz
   localparam longint MCLK_HZ = 20000000;
   localparam longint MP_BASE_HZ = 117964800;
   localparam longint HW_BASE_HZ = 19660800;
   localparam logic [35:0] NCO_MOD2 = 36'(2 * MCLK_HZ / 100);
   localparam logic [35:0] MP_INC = 36'(MP_BASE_HZ / 100);
   localparam logic [18:0] HW_MOD = 19'(MCLK_HZ / 100);
   localparam logic [18:0] HW_INC = 19'(HW_BASE_HZ / 100);
   // Serial frame
   localparam logic [4:0] FRAME_BITS = 5'd24;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// File: sim/dac_serial_model.sv
// Behavioural serial DAC receiver on channel 0 of the low bank
`timescale 1ns/1ps
module dac_serial_model (
   input wire logic mclk, // Block clock
   input wire logic rst, // Sync reset, high
   input wire logic dacTick, // DAC serial clock pulse
   input wire logic phaseTick, // Phase cycle start
   input wire logic strobeIn, // Serial strobe bit
   input wire logic dataA, // Serial data, DAC A
   input wire logic dataB, // Serial data, DAC B
   output logic [23:0] strobeWord, // Last strobe frame
   output logic [23:0] wordA, // Last DAC A frame
   output logic [23:0] wordB, // Last DAC B frame
   output int frames // Frames received
);
   logic [23:0] shS, shA, shB;
   int bitCnt;
   //////////////////////////////////////////////////////////////////////
   // MSB first, frame restarts each phase cycle
   // A bit stands in the same cycle as its DAC tick pulse
   always_ff @(posedge mclk) begin
      if (rst) begin
         bitCnt <= 0;
         frames <= 0;
      end else if (phaseTick) begin
         bitCnt <= 0;
      end else if (dacTick && bitCnt < 24) begin
         shS <= {shS[22:0], strobeIn};
         shA <= {shA[22:0], dataA};
         shB <= {shB[22:0], dataB};
         bitCnt <= bitCnt + 1;
         if (bitCnt == 23) begin
            strobeWord <= {shS[22:0], strobeIn};
            wordA <= {shA[22:0], dataA};
            wordB <= {shB[22:0], dataB};
            frames <= frames + 1;
         end
      end
   end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the phase/servo clock and serial DAC block
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, maxPhaseTick, phaseTick, servoTick;
   logic [1:0] bresp, rresp, dacStrobe;
   logic [31:0] rdata;
   logic [7:0] commutateStb, servoUpdStb, hwClkTick, phaseAAnalogOut, phaseBAnalogOut;
   logic [7:0] quadX4, countUpDir, outCPfm;
   logic [23:0] strobeWord, wordA, wordB, exA, exB;
   logic [39:0] rstTab [10] = '{{8'h00, 32'h197F}, {8'h04, 32'h0}, {8'h08, 32'h3},
      {8'h0C, 32'h492}, {8'h10, 32'h492}, {8'h14, 32'h7FFFC0}, {8'h18, 32'h7FFFC0},
      {8'h1C, 32'h38ABF3}, {8'h40, 32'h13}, {8'h60, 32'h0}};
   logic [8:0] dm [4] = '{9'h003, 9'h007, 9'h031, 9'h016};
   logic [8:0] dc [4] = '{9'h013, 9'h113, 9'h003, 9'h033};
   int hiSel [4] = '{1, 3, 2, 4};
   int divs [3] = '{0, 3, 15};
   int frames, f, mismatches = 0, numChecks = 0, cycles = 0;
   phase_servo_clock u_phase_servo_clock (.mclk, .rst, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .maxPhaseTick, .phaseTick, .servoTick, .commutateStb,
      .servoUpdStb, .hwClkTick, .dacStrobe, .phaseAAnalogOut, .phaseBAnalogOut, .quadX4,
      .countUpDir, .outCPfm);
   dac_serial_model u_dac_serial_model (.mclk, .rst, .dacTick(hwClkTick[2]), .phaseTick,
      .strobeIn(dacStrobe[0]), .dataA(phaseAAnalogOut[0]), .dataB(phaseBAnalogOut[0]),
      .strobeWord, .wordA, .wordB, .frames);
   //////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         end_of_test();
      end
   end
   //////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic end_of_test();
      if (mismatches == 0 && numChecks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // AXI4-Lite write, address and data offered together
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge mclk);
         if (awvalid && awready) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   // AXI4-Lite read
   task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axiWr(a, d, r);
   endtask
   // Tick selector: hw clocks, then max-phase, phase, servo
   function automatic logic sig(input int s);
      return s < 8 ? hwClkTick[s] : s == 8 ? maxPhaseTick : s == 9 ? phaseTick : servoTick;
   endfunction
   task automatic waitTick(input int s);
      do begin
         @(posedge mclk);
         #1;
      end while (sig(s) !== 1'b1);
   endtask
   // Count ticks in a window; fractional rates allow one tick of jitter
   task automatic rate(input int s, input int w, input real ex, input string n);
      int k;
      k = 0;
      repeat (w) begin
         @(posedge mclk);
         #1;
         if (sig(s) === 1'b1) k++;
      end
      `CHK(n, 1'b1, (k >= ex - 1.0 && k <= ex + 1.0))
   endtask
   // Ticks of a over k periods of b
   task automatic ratio(input int a, input int b, input int k, input int ex, input string n);
      int c;
      c = 0;
      waitTick(b);
      waitTick(b);
      repeat (k) begin
         do begin
            @(posedge mclk);
            #1;
            if (sig(a) === 1'b1) c++;
         end while (sig(b) !== 1'b1);
      end
      `CHK(n, ex, c)
   endtask
   //////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int svi;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      foreach (rstTab[i]) begin
         axiRd(rstTab[i][39:32], d, r);
         `CHK("reset value", rstTab[i][31:0], d)
      end
      axiRd(8'h30, d, r);
      `CHK("unmapped read", phase_servo_pkg::RESP_ERR, r)
      axiWr(8'h30, 32'h1, r);
      `CHK("unmapped write", phase_servo_pkg::RESP_ERR, r)
      rate(9, 20000, 20000.0 * 117964800.0 / 13056.0 / 20.0e6, "phase rate");
      for (int i = 0; i < 8; i++) begin
         rate(i, 1000, 1000.0 * 19660800.0 / 4.0 / 20.0e6, "hw clock");
      end
      wr(phase_servo_pkg::OFF_HWHI, 32'h899);
      foreach (hiSel[i]) begin
         rate(4 + i, 1000, 1000.0 * 19660800.0 / (2.0 ** hiSel[i]) / 20.0e6, "hw hi");
      end
      wr(phase_servo_pkg::OFF_MAXPH, 32'd58);
      waitTick(8);
      rate(8, 4000, 4000.0 * 117964800.0 / 118.0 / 20.0e6, "max phase rate");
      foreach (divs[i]) begin
         wr(phase_servo_pkg::OFF_PHDIV, divs[i]);
         wr(phase_servo_pkg::OFF_SVDIV, divs[i]);
         svi = 640 * (2 * 58 + 3) * (divs[i] + 1) * (divs[i] + 1) / 9;
         wr(phase_servo_pkg::OFF_SVINT, svi);
         axiRd(phase_servo_pkg::OFF_SVINT, d, r);
         `CHK("servo interval", 32'(svi), d)
         ratio(8, 9, 2, 2 * (divs[i] + 1), "phase ratio");
         ratio(9, 10, 2, 2 * (divs[i] + 1), "servo ratio");
      end
      wr(8'h60, 32'h3);
      wr(8'h64, 32'h1);
      wr(8'h68, 32'h2);
      wr(phase_servo_pkg::OFF_PHDIV, 32'd7);
      wr(phase_servo_pkg::OFF_SVDIV, 32'd1);
      repeat (6) begin
         waitTick(9);
         `CHK("commutate", 8'h01, commutateStb)
         `CHK("servo update", (servoTick === 1'b1) ? 8'h03 : 8'h00, servoUpdStb)
      end
      foreach (dm[i]) begin
         wr(8'h48, dm[i]);
         wr(8'h68, dm[i][2] ? 32'h2AE : 32'h156);
         repeat (2) @(posedge mclk);
         #1;
         `CHK("x4 decode", dm[i][1:0] == 2'b11, quadX4[2])
         `CHK("count dir", dm[i][2], countUpDir[2])
         `CHK("output C pfm", dm[i][5:4] == 2'b11, outCPfm[2])
      end
      wr(phase_servo_pkg::OFF_STBLO, 32'hA5C3F0);
      wr(8'h80, 32'h5A0F1234);
      foreach (dc[i]) begin
         wr(8'h40, dc[i]);
         exA = dc[i][4] ? ({16'h1234, 8'h00} ^ {24{dc[i][8]}}) : 24'h0;
         exB = dc[i][4] ? ({16'h5A0F, 8'h00} ^ {24{dc[i][8]}}) : 24'h0;
         f = frames;
         while (frames < f + 2) @(posedge mclk);
         `CHK("strobe word", 24'hA5C3F0, strobeWord)
         `CHK("dac A word", exA, wordA)
         `CHK("dac B word", exB, wordB)
      end
      end_of_test();
   end
endmodule
